//--- core/config_seq_regs.vh
`ifndef CONFIG_SEQ_REGS_VH
`define CONFIG_SEQ_REGS_VH

// sequencer states
`define ST_POR_SAMPLE 4'h0
`define ST_POR_WAIT 4'h1
`define ST_RESET_HOLD 4'h2
`define ST_CLEAR 4'h3
`define ST_LOAD 4'h4
`define ST_STARTUP 4'h5
`define ST_USER 4'h6
`define ST_PD 4'h7
`define ST_PD_EXIT 4'h8

// synchroniser bit positions
`define SY_PD 0
`define SY_RST 1
`define SY_M0 2
`define SY_M1 3
`define SY_M2 4
`define SY_DONE 5
`define SY_CONFIG_CLOCK 6
`define SY_W 7
`define SY_RESET_VAL 7'h7F

// timing: system clock and internal oscillator periods
`define CLK_PERIOD_NS 20
`define OSC_PERIOD_NS 1000
`define OSC_DIV (`OSC_PERIOD_NS / `CLK_PERIOD_NS)

// power-on time-out in oscillator cycles, by mode line zero level
`define TIMEOUT_M0_HIGH 17'h04000
`define TIMEOUT_M0_LOW 17'h10000

// done held low after power-down exit, in oscillator cycles
`define PD_DONE_LOW_TICKS 2'h2

// start-up sequence steps
`define STEP_CLEAR 2'h0
`define STEP_FIRST 2'h1
`define STEP_SECOND 2'h2

// mode line encoding of the slave mode (clock is an input)
`define MODE_SLAVE 3'h7

// readback option encoding
`define RB_OPT_ANY 2'h0
`define RB_OPT_ONCE 2'h1
`define RB_OPT_OFF 2'h2

`endif

//--- core/config_control_power_down_sequencer.v
// Function
// [R01] power-down halts, clears state, floats outputs, inputs high
// [R02] power-down disables drivers and weak pull-ups
// [R03] power-up exit holds done low two oscillator cycles; the code applies this hold on power-down exit
// [R04] power-down exit replays start-up sequence
// [R05] controller keeps power-down high during configuration
// [R06] power-on time-out length chosen by mode zero
// [R07] reset low delays configuration start
// [R08] all three mode lines sampled together
// [R09] reset during configuration restarts configuration
// [R10] reset after configuration clears storage asynchronously
// [R11] configuration clock direction by mode; readback input
// [R12] external clock low phase short, parked high
// [R13] done open-drain, before or after outputs enable
// [R14] done falling edge after configuration reconfigures
// [R15] mode zero rising edge triggers readback
// [R16] readback option: once only or disabled
// [R17] readback data active low on mode one
// [R18] mode two pull-up during configuration, then user
// [R19] high progress output high until configured
// [R20] low progress output low until configured
// [R21] init status low during power-up and clearing
// [R22] asynchronous inputs synchronised before use
`timescale 1ns/10ps
`include "config_seq_regs.vh"

module config_control_power_down_sequencer #(
  parameter TIMEOUT_SHORT = `TIMEOUT_M0_HIGH, // power-on delay, mode zero high
  parameter TIMEOUT_LONG = `TIMEOUT_M0_LOW,   // power-on delay, mode zero low
  parameter CLEAR_TICKS = 4,                  // memory clear time, oscillator cycles
  parameter CONFIG_CLOCK_HALF = 25,                   // master clock half period, clk cycles
  parameter RB_W = 8,                         // readback word width
  parameter RB_BITS = 64                      // readback frame length in bits
) (
  input wire clk_i,
  input wire rstn_i,
  input wire ce_i,
  input wire power_down_n_i,
  input wire reset_n_i,
  input wire mode_line_zero_read_trigger_i,
  input wire mode_line_one_i,
  output wire mode_line_one_read_out_o,
  output wire mode_line_one_read_out_oe_o,
  input wire mode_line_two_i,
  output wire mode_line_two_pullup_o,
  input wire config_clock_i,
  output wire config_clock_o,
  output wire config_clock_oe_o,
  input wire config_complete_pin_i,
  output wire config_complete_pin_o,
  output wire config_complete_pin_oe_o,
  input wire done_pullup_opt_i,
  output wire done_pullup_o,
  input wire done_early_opt_i,
  input wire [1:0] readback_opt_i,
  output wire config_progress_high_o,
  output wire config_progress_high_oe_o,
  output wire config_progress_low_o,
  output wire config_progress_low_oe_o,
  output wire init_n_o,
  output wire init_n_oe_o,
  output wire io_pullup_o,
  output wire [2:0] mode_sel_o,
  output wire config_start_o,
  input wire load_done_i,
  output wire storage_reset_o,
  output wire outputs_enable_o,
  output wire configured_o,
  output wire readback_active_o,
  input wire [RB_W-1:0] rb_data_i,
  input wire rb_valid_i,
  output wire rb_ready_o
);

  reg [`SY_W-1:0] sy1_q;       // first synchroniser stage
  reg [`SY_W-1:0] sy2_q;       // second synchroniser stage
  reg [`SY_W-1:0] prev_q;      // previous effective input levels
  wire pd;                     // power-down requested
  wire [`SY_W-1:0] in_eff;     // inputs as the logic sees them
  reg [3:0] state_q;           // sequencer state
  reg [3:0] state_d;
  reg [5:0] osc_cnt_q;         // internal oscillator divider
  wire osc_tick;               // one pulse per oscillator cycle
  reg [16:0] tmo_q;            // time-out and step counter
  reg [16:0] tmo_limit_q;      // power-on time-out chosen at power-up
  reg [1:0] step_q;            // start-up sequence step
  reg [2:0] mode_q;            // sampled configuration mode
  reg start_q;                 // configuration start pulse
  reg done_rel_q;              // done pin released
  reg out_en_q;                // user outputs enabled
  reg clr_q;                   // storage clear during start-up
  reg cfg_valid_q;             // configuration memory holds a design
  reg rb_used_q;               // one readback already taken
  reg rb_act_q;                // readback in progress
  reg [15:0] rb_cnt_q;         // readback bits left
  reg [RB_W-1:0] shift_q;      // readback shift register
  reg [7:0] shift_left_q;      // bits left in shift register
  reg rdata_q;                 // readback bit on the pin, true level
  reg [5:0] config_clock_cnt_q;        // master clock divider
  reg config_clock_q;                  // master clock output level
  reg [RB_W-1:0] buf_q [0:1];  // two-entry readback buffer
  reg wr_ptr_q;
  reg rd_ptr_q;
  reg [1:0] fill_q;
  wire buf_push;
  wire buf_pop;
  wire rb_start;
  wire config_clock_rise;
  wire done_fall;
  wire m0_rise;
  wire in_user;

  // rising edge of a level seen through the effective inputs
  function rise;
    input [`SY_W-1:0] now;
    input [`SY_W-1:0] was;
    input integer bit_i;
    begin
      rise = now[bit_i] & ~was[bit_i];
    end
  endfunction

  // two-stage synchronisers on every pin input
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sy1_q <= `SY_RESET_VAL;
      sy2_q <= `SY_RESET_VAL;
    end else if (ce_i) begin
      sy1_q <= {config_clock_i, config_complete_pin_i, mode_line_two_i,
                mode_line_one_i, mode_line_zero_read_trigger_i, reset_n_i,
                power_down_n_i}; // [R22]
      sy2_q <= sy1_q; // [R22]
    end
  end

  // while powered down every input reads high
  assign pd = ~sy2_q[`SY_PD];
  assign in_eff = sy2_q | {`SY_W{pd}}; // [R01]

  // edge history of the effective inputs
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prev_q <= `SY_RESET_VAL;
    end else if (ce_i) begin
      prev_q <= in_eff;
    end
  end

  assign config_clock_rise = rise(in_eff, prev_q, `SY_CONFIG_CLOCK);
  assign done_fall = rise(prev_q, in_eff, `SY_DONE);
  assign m0_rise = rise(in_eff, prev_q, `SY_M0);
  assign in_user = (state_q == `ST_USER);

  // internal 1-MHz oscillator derived from the system clock
  assign osc_tick = (osc_cnt_q == (`OSC_DIV - 1));
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      osc_cnt_q <= 6'h00;
    end else if (ce_i) begin
      if (osc_tick || pd) begin
        osc_cnt_q <= 6'h00;
      end else begin
        osc_cnt_q <= osc_cnt_q + 6'h01;
      end
    end
  end

  // sequencer next state
  always @* begin
    state_d = state_q;
    case (state_q)
      `ST_POR_SAMPLE: begin
        if (osc_tick) state_d = `ST_POR_WAIT;
      end
      `ST_POR_WAIT: begin
        if (osc_tick && tmo_q == tmo_limit_q) begin
          state_d = in_eff[`SY_RST] ? `ST_CLEAR : `ST_RESET_HOLD; // [R07]
        end
      end
      `ST_RESET_HOLD: begin
        if (in_eff[`SY_RST]) state_d = `ST_CLEAR; // [R07] [R09]
      end
      `ST_CLEAR: begin
        if (!in_eff[`SY_RST]) begin
          state_d = `ST_RESET_HOLD; // [R07]
        end else if (osc_tick && tmo_q == CLEAR_TICKS - 1) begin
          state_d = `ST_LOAD;
        end
      end
      `ST_LOAD: begin
        if (!in_eff[`SY_RST]) begin
          state_d = `ST_RESET_HOLD; // [R09]
        end else if (load_done_i) begin
          state_d = `ST_STARTUP;
        end
      end
      `ST_STARTUP: begin
        if (osc_tick && step_q == `STEP_SECOND) state_d = `ST_USER;
      end
      `ST_USER: begin
        if (done_fall) state_d = `ST_CLEAR; // [R14]
      end
      `ST_PD: begin
        if (!pd) state_d = `ST_PD_EXIT;
      end
      `ST_PD_EXIT: begin
        if (osc_tick && tmo_q == `PD_DONE_LOW_TICKS - 1) begin
          state_d = cfg_valid_q ? `ST_STARTUP : `ST_CLEAR; // [R04]
        end
      end
      default: state_d = `ST_POR_SAMPLE;
    endcase
    if (pd) state_d = `ST_PD; // [R01]
  end

  // sequencer registers, counters and start-up steps
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= `ST_POR_SAMPLE;
      tmo_q <= 17'h00000;
      tmo_limit_q <= 17'h00000;
      step_q <= `STEP_CLEAR;
      mode_q <= 3'h0;
      start_q <= 1'b0;
      done_rel_q <= 1'b0;
      out_en_q <= 1'b0;
      clr_q <= 1'b0;
      cfg_valid_q <= 1'b0;
    end else if (ce_i) begin
      state_q <= state_d;
      start_q <= 1'b0;
      // time-out counter restarts on every state change
      if (state_d != state_q) begin
        tmo_q <= 17'h00000;
      end else if (osc_tick) begin
        tmo_q <= tmo_q + 17'h00001;
      end
      // mode zero picks the power-on delay
      if (state_q == `ST_POR_SAMPLE && osc_tick) begin
        tmo_limit_q <= in_eff[`SY_M0] ? TIMEOUT_SHORT[16:0] - 17'h00001
                                      : TIMEOUT_LONG[16:0] - 17'h00001; // [R06]
      end
      // all mode lines sampled at once as configuration begins
      if (state_q == `ST_CLEAR && state_d == `ST_LOAD) begin
        mode_q <= {in_eff[`SY_M2], in_eff[`SY_M1], in_eff[`SY_M0]}; // [R08]
        start_q <= 1'b1; // [R07]
      end
      // start-up: clear storage, then done and outputs in programmed order
      if (state_d == `ST_STARTUP && state_q != `ST_STARTUP) begin
        step_q <= `STEP_CLEAR;
        clr_q <= 1'b1; // [R04]
        cfg_valid_q <= 1'b1;
      end else if (state_q == `ST_STARTUP && osc_tick) begin
        step_q <= step_q + 2'h1;
        clr_q <= 1'b0;
        if (step_q == `STEP_CLEAR) begin
          if (done_early_opt_i) begin
            done_rel_q <= 1'b1; // [R13]
          end else begin
            out_en_q <= 1'b1; // [R13] [R04]
          end
        end else begin
          done_rel_q <= 1'b1; // [R04]
          out_en_q <= 1'b1;
        end
      end
      // leaving user mode for any reason drops done and outputs
      if (state_d != `ST_USER && state_d != `ST_STARTUP) begin
        done_rel_q <= 1'b0; // [R03] [R14]
        out_en_q <= 1'b0;
      end
      if (state_d == `ST_CLEAR) cfg_valid_q <= 1'b0; // [R14]
      if (state_q == `ST_PD) clr_q <= 1'b0;
    end
  end

  // master clock divider, runs only while loading
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      config_clock_cnt_q <= 6'h00;
      config_clock_q <= 1'b1;
    end else if (ce_i) begin
      if (state_q != `ST_LOAD) begin
        config_clock_cnt_q <= 6'h00;
        config_clock_q <= 1'b1;
      end else if (config_clock_cnt_q == CONFIG_CLOCK_HALF - 1) begin
        config_clock_cnt_q <= 6'h00;
        config_clock_q <= ~config_clock_q; // [R11]
      end else begin
        config_clock_cnt_q <= config_clock_cnt_q + 6'h01;
      end
    end
  end

  // readback trigger honours the bitstream option
  assign rb_start = in_user && out_en_q && m0_rise && !rb_act_q &&
                    readback_opt_i != `RB_OPT_OFF &&
                    !(readback_opt_i == `RB_OPT_ONCE && rb_used_q); // [R15] [R16]

  // two-entry buffer between readback source and shifter
  assign rb_ready_o = (fill_q != 2'h2);
  assign buf_push = rb_valid_i && rb_ready_o;
  assign buf_pop = rb_act_q && config_clock_rise && shift_left_q == 8'h00 && fill_q != 2'h0;
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      fill_q <= 2'h0;
    end else if (ce_i) begin
      if (buf_push) wr_ptr_q <= ~wr_ptr_q;
      if (buf_pop) rd_ptr_q <= ~rd_ptr_q;
      if (pd) begin
        fill_q <= 2'h0;
      end else if (buf_push && !buf_pop) begin
        fill_q <= fill_q + 2'h1;
      end else if (buf_pop && !buf_push) begin
        fill_q <= fill_q - 2'h1;
      end
    end
  end

  // buffer storage, no reset needed on data words
  always @(posedge clk_i) begin
    if (ce_i && buf_push) buf_q[wr_ptr_q] <= rb_data_i;
  end

  // readback shifter clocked by rising edges of the configuration clock
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rb_act_q <= 1'b0;
      rb_used_q <= 1'b0;
      rb_cnt_q <= 16'h0000;
      shift_q <= {RB_W{1'b0}};
      shift_left_q <= 8'h00;
      rdata_q <= 1'b0;
    end else if (ce_i) begin
      if (!in_user) begin
        rb_act_q <= 1'b0;
        shift_left_q <= 8'h00;
        rdata_q <= 1'b0;
        if (state_q == `ST_CLEAR) rb_used_q <= 1'b0;
      end else if (rb_start) begin
        rb_act_q <= 1'b1;
        rb_used_q <= 1'b1; // [R16]
        rb_cnt_q <= RB_BITS[15:0];
      end else if (rb_act_q && config_clock_rise) begin
        if (rb_cnt_q == 16'h0000) begin
          rb_act_q <= 1'b0;
          rdata_q <= 1'b0;
        end else if (shift_left_q != 8'h00) begin
          rdata_q <= shift_q[RB_W-1]; // [R11]
          shift_q <= {shift_q[RB_W-2:0], 1'b0};
          shift_left_q <= shift_left_q - 8'h01;
          rb_cnt_q <= rb_cnt_q - 16'h0001;
        end else if (fill_q != 2'h0) begin
          rdata_q <= buf_q[rd_ptr_q][RB_W-1];
          shift_q <= {buf_q[rd_ptr_q][RB_W-2:0], 1'b0};
          shift_left_q <= RB_W[7:0] - 8'h01;
          rb_cnt_q <= rb_cnt_q - 16'h0001;
        end
      end
    end
  end

  // pin drivers; all float and pull-ups off while powered down
  assign mode_line_one_read_out_o = ~rdata_q; // [R17]
  assign mode_line_one_read_out_oe_o = in_user && out_en_q && !pd; // [R17] [R02]
  assign mode_line_two_pullup_o = !cfg_valid_q && !pd; // [R18] [R02]
  assign io_pullup_o = !out_en_q && !pd; // [R02]
  assign config_clock_o = config_clock_q;
  assign config_clock_oe_o = (state_q == `ST_LOAD) && (mode_q != `MODE_SLAVE); // [R11]
  assign config_complete_pin_o = 1'b0; // [R13]
  assign config_complete_pin_oe_o = !done_rel_q && !pd; // [R13] [R03] [R02]
  assign done_pullup_o = done_pullup_opt_i && !pd; // [R13] [R02]
  assign config_progress_high_o = 1'b1; // [R19]
  assign config_progress_high_oe_o = !cfg_valid_q && !pd; // [R19]
  assign config_progress_low_o = 1'b0; // [R20]
  assign config_progress_low_oe_o = !cfg_valid_q && !pd; // [R20]
  assign init_n_o = 1'b0; // [R21]
  assign init_n_oe_o = (state_q == `ST_POR_SAMPLE || state_q == `ST_POR_WAIT ||
                        state_q == `ST_CLEAR) && !pd; // [R21]

  // towards the configuration engine and user logic
  assign mode_sel_o = mode_q;
  assign config_start_o = start_q;
  assign storage_reset_o = clr_q || pd || (in_user && !in_eff[`SY_RST]); // [R10] [R01]
  assign outputs_enable_o = out_en_q && !pd; // [R01]
  assign configured_o = in_user;
  assign readback_active_o = rb_act_q && in_user; // [R15]

endmodule

//--- testbench/config_seq_assertions.sv
`timescale 1ns/10ps
`include "config_seq_regs.vh"
// pin-level checks of the sequencer, bound to its top module
module config_seq_assertions (
  input wire clk_i,
  input wire rstn_i,
  input wire power_down_n_i,
  input wire reset_n_i,
  input wire mode_line_zero_read_trigger_i,
  input wire mode_line_one_i,
  input wire mode_line_two_i,
  input wire config_complete_pin_o,
  input wire config_complete_pin_oe_o,
  input wire config_clock_oe_o,
  input wire mode_line_one_read_out_oe_o,
  input wire mode_line_two_pullup_o,
  input wire done_pullup_o,
  input wire config_progress_high_o,
  input wire config_progress_high_oe_o,
  input wire config_progress_low_o,
  input wire config_progress_low_oe_o,
  input wire init_n_o,
  input wire init_n_oe_o,
  input wire io_pullup_o,
  input wire [2:0] mode_sel_o,
  input wire config_start_o,
  input wire storage_reset_o,
  input wire outputs_enable_o,
  input wire configured_o,
  input wire readback_active_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // power-down pin held low long enough to pass the synchroniser
  sequence s_pd_held;
    !power_down_n_i [*3];
  endsequence
  // reset pin held low one cycle beyond the synchroniser depth
  sequence s_reset_low;
    !reset_n_i [*3];
  endsequence
  // reset pin low while the device is configured
  sequence s_user_reset;
    (configured_o && !reset_n_i) [*4];
  endsequence
  AST_PD_FLOAT: assert property (s_pd_held |=> !outputs_enable_o && !init_n_oe_o
    && !config_complete_pin_oe_o && !config_clock_oe_o && !mode_line_one_read_out_oe_o
    && !io_pullup_o && !mode_line_two_pullup_o && !done_pullup_o && storage_reset_o)
    else $error("power-down left a driver, pull-up or storage element active");
  AST_DONE_OPEN_DRAIN: assert property (!config_complete_pin_o)
    else $error("done pin driven high");
  AST_HIGH_PROGRESS: assert property (config_progress_high_oe_o |->
    config_progress_high_o && !configured_o) else $error("high progress pin wrong");
  AST_LOW_PROGRESS: assert property (config_progress_low_oe_o |->
    !config_progress_low_o && !configured_o) else $error("low progress pin wrong");
  AST_INIT_LOW: assert property (init_n_oe_o |-> !init_n_o && !configured_o)
    else $error("init status wrong");
  AST_MODE_SAMPLE: assert property (config_start_o |-> mode_sel_o ==
    $past({mode_line_two_i, mode_line_one_i, mode_line_zero_read_trigger_i}, 3))
    else $error("mode select differs from mode lines");
  AST_CLOCK_DIR: assert property (config_clock_oe_o |-> mode_sel_o != `MODE_SLAVE)
    else $error("clock driven in slave mode");
  AST_RESET_HOLDS: assert property (s_reset_low |=> !config_start_o)
    else $error("configuration started under reset");
  AST_USER_CLEAR: assert property (s_user_reset |-> storage_reset_o)
    else $error("reset after configuration did not clear storage");
  AST_M2_RELEASE: assert property (configured_o |-> !mode_line_two_pullup_o)
    else $error("mode two pull-up kept after configuration");
  AST_RB_AFTER_CFG: assert property (readback_active_o |-> configured_o)
    else $error("readback outside configured state");
endmodule
bind config_control_power_down_sequencer config_seq_assertions u_config_seq_assertions (
  .clk_i, .rstn_i, .power_down_n_i, .reset_n_i, .mode_line_zero_read_trigger_i,
  .mode_line_one_i, .mode_line_two_i, .config_complete_pin_o, .config_complete_pin_oe_o,
  .config_clock_oe_o, .mode_line_one_read_out_oe_o, .mode_line_two_pullup_o, .done_pullup_o,
  .config_progress_high_o, .config_progress_high_oe_o, .config_progress_low_o,
  .config_progress_low_oe_o, .init_n_o, .init_n_oe_o, .io_pullup_o, .mode_sel_o,
  .config_start_o, .storage_reset_o, .outputs_enable_o, .configured_o, .readback_active_o);

//--- testbench/config_host_model.sv
`timescale 1ns/10ps
// board controller side: configuration clock, done wire and mode-one wire
module config_host_model (
  input wire run_i,
  input wire pull_low_i,
  input wire done_oe_i,
  input wire m1_strap_i,
  input wire m1_oe_i,
  input wire m1_dev_i,
  output logic config_clock_o,
  output wire done_pin_o,
  output wire m1_pin_o
);
  // wired-and done line with pull-up, host may pull low to reprogram
  assign done_pin_o = ~(done_oe_i | pull_low_i);
  // mode one strap resistor, overdriven by readback data
  assign m1_pin_o = m1_oe_i ? m1_dev_i : m1_strap_i;
  // clock parked high outside frames, 80 ns low phase, off the system clock grid
  initial config_clock_o = 1'b1;
  always begin
    wait (run_i);
    #3;
    while (run_i) begin
      #80 config_clock_o = 1'b0;
      #80 config_clock_o = 1'b1;
    end
  end
endmodule

//--- testbench/config_control_power_down_sequencer_tb.sv
`timescale 1ns/10ps
// boots through four modes, then readback, reprogram, power-down and user reset
module config_control_power_down_sequencer_tb;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic pd_n = 1'b1;
  logic reset_n = 1'b1, m0 = 1'b0, m1 = 1'b0, m2 = 1'b0, pull_low = 1'b0, run = 1'b0;
  logic load_done = 1'b0, rb_valid = 1'b0;
  logic ce = 1'b1, done_early = 1'b0, dpu_opt = 1'b1;
  logic [7:0] rb_data = 8'h00;
  logic [1:0] rb_opt = 2'h1; // readback allowed once
  logic [3:0] rows [4] = '{4'hE, 4'h1, 4'hB, 4'h5}; // mode lines, clock driven
  logic [15:0] rb_exp = 16'hA53C; // readback words, first bit first
  wire config_clock, done_pin, m1_pin, rd_out, rd_oe, m2_pu, config_clock_oe, done_oe, hp, hp_oe, lp, lp_oe;
  wire init_oe, io_pu, start, sreset, oen, cfg, rb_act, rb_rdy, mclk, dpu;
  wire [2:0] msel;
  int num_errors = 0, num_checks = 0, cyc = 0, n;
  always #10 clk_i = ~clk_i;
  config_host_model u_config_host_model (.run_i(run), .pull_low_i(pull_low),
    .done_oe_i(done_oe), .m1_strap_i(m1), .m1_oe_i(rd_oe), .m1_dev_i(rd_out),
    .config_clock_o(config_clock), .done_pin_o(done_pin), .m1_pin_o(m1_pin));
  config_control_power_down_sequencer #(.TIMEOUT_SHORT(4), .TIMEOUT_LONG(8),
    .RB_BITS(16)) u_config_control_power_down_sequencer (.clk_i(clk_i),
    .rstn_i(rstn_i), .ce_i(ce), .power_down_n_i(pd_n), .reset_n_i(reset_n),
    .mode_line_zero_read_trigger_i(m0), .mode_line_one_i(m1_pin),
    .mode_line_one_read_out_o(rd_out), .mode_line_one_read_out_oe_o(rd_oe),
    .mode_line_two_i(m2), .mode_line_two_pullup_o(m2_pu), .config_clock_i(config_clock),
    .config_clock_o(mclk), .config_clock_oe_o(config_clock_oe), .config_complete_pin_i(done_pin),
    .config_complete_pin_o(), .config_complete_pin_oe_o(done_oe),
    .done_pullup_opt_i(dpu_opt), .done_pullup_o(dpu), .done_early_opt_i(done_early),
    .readback_opt_i(rb_opt),
    .config_progress_high_o(hp), .config_progress_high_oe_o(hp_oe),
    .config_progress_low_o(lp), .config_progress_low_oe_o(lp_oe), .init_n_o(),
    .init_n_oe_o(init_oe), .io_pullup_o(io_pu), .mode_sel_o(msel), .config_start_o(start),
    .load_done_i(load_done), .storage_reset_o(sreset), .outputs_enable_o(oen),
    .configured_o(cfg), .readback_active_o(rb_act), .rb_data_i(rb_data),
    .rb_valid_i(rb_valid), .rb_ready_o(rb_rdy));
  // compare a design value
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // compare a cycle count against a window
  task chk_rng(input string what, input int lo, input int hi, input int got);
    num_checks++;
    if (got < lo || got > hi) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  // count cycles until the start pulse (0) or the configured state (1)
  task wait_for(input int which, output int c);
    c = 0;
    do begin
      @(negedge clk_i);
      c++;
    end while (c < 2000 && (which ? cfg : start) !== 1'b1);
  endtask
  // one load-done pulse, then wait for the user state
  task load;
    @(posedge clk_i) load_done <= 1'b1;
    @(posedge clk_i) load_done <= 1'b0;
    wait_for(1, n);
    chk("cfg_outs", 8'h01, {hp_oe, lp_oe, init_oe, io_pu, done_oe, m2_pu, oen});
  endtask
  // push one word into the readback buffer, holding it until taken
  task push(input logic [7:0] w);
    logic ok;
    @(posedge clk_i);
    rb_data <= w;
    rb_valid <= 1'b1;
    do begin
      @(negedge clk_i) ok = rb_rdy;
      @(posedge clk_i);
    end while (ok !== 1'b1);
    rb_valid <= 1'b0;
  endtask
  // the run ends here only
  task stop_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // cycle ceiling against a hang
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      $display("CHECK FAILED timeout expected 0 seen %0d", cyc);
      stop_test;
    end
  end
  initial begin
    // power-on boot in four modes
    foreach (rows[i]) begin
      @(posedge clk_i);
      rstn_i <= 1'b0;
      {m2, m1, m0} <= rows[i][3:1];
      repeat (3) @(posedge clk_i);
      chk("por_outs", 8'h3F, {init_oe, done_oe, hp, hp_oe, m2_pu, dpu});
      rstn_i <= 1'b1;
      wait_for(0, n);
      chk_rng("timeout", (rows[i][1] ? 8 : 12) * 50, (rows[i][1] ? 10 : 14) * 50, n);
      chk("mode_sel", rows[i][3:1], msel);
      @(negedge clk_i) chk("clk_dir", rows[i][0], config_clock_oe);
      chk("load_outs", 8'h1B, {hp, hp_oe, lp, lp_oe, m2_pu});
      // master clock divider toggles after its first half period of loading
      repeat (30) @(negedge clk_i);
      chk("mclk", 8'h00, mclk);
      load;
      $display("test boot %0d done", i);
    end
    // fill the buffer until refused, then read back through the slave clock
    push(8'hA5);
    push(8'h3C);
    @(negedge clk_i) chk("buf_full", 8'h00, rb_rdy);
    @(posedge clk_i) m0 <= 1'b1;
    repeat (10) @(posedge clk_i);
    run = 1'b1;
    for (int b = 15; b >= 0; b--) begin
      @(posedge config_clock);
      repeat (4) @(negedge clk_i);
      chk("rdata", {7'h00, ~rb_exp[b]}, {7'h00, rd_out});
      chk("rb_act", 8'h01, rb_act);
    end
    @(negedge config_clock);
    run = 1'b0;
    @(posedge config_clock);
    repeat (4) @(negedge clk_i);
    repeat (4) @(negedge clk_i) chk("rb_end", 8'h00, rb_act);
    @(posedge clk_i) m0 <= 1'b0;
    repeat (5) @(posedge clk_i);
    m0 <= 1'b1;
    repeat (10) @(posedge clk_i);
    chk("rb_once", 8'h00, rb_act);
    // unlimited option lets the trigger start again; reprogram cancels it
    @(posedge clk_i) m0 <= 1'b0;
    rb_opt <= 2'h0;
    repeat (5) @(posedge clk_i);
    m0 <= 1'b1;
    repeat (10) @(posedge clk_i);
    chk("rb_any", 8'h01, rb_act);
    $display("test readback done");
    // reprogram by pulling done low, then reset during configuration
    pull_low <= 1'b1;
    repeat (20) @(posedge clk_i);
    chk("reprog", 8'h01, {cfg, init_oe});
    repeat (280) @(posedge clk_i);
    pull_low <= 1'b0;
    reset_n <= 1'b0;
    repeat (300) @(posedge clk_i);
    reset_n <= 1'b1;
    wait_for(0, n);
    chk_rng("restart", 1, 500, n);
    load;
    $display("test reprogram done");
    // power-down and exit, done released ahead of the outputs this time
    @(posedge clk_i) pd_n <= 1'b0;
    done_early <= 1'b1;
    repeat (10) @(posedge clk_i);
    chk("pd", 8'h02, {oen, sreset, dpu});
    pd_n <= 1'b1;
    repeat (60) @(posedge clk_i);
    chk("pd_done", 8'h01, {cfg, done_oe});
    wait (done_oe === 1'b0);
    @(negedge clk_i) chk("done_first", 8'h00, oen);
    wait_for(1, n);
    chk_rng("pd_exit", 1, 400, n);
    chk("pd_user", 8'h01, {done_oe, oen});
    $display("test power_down done");
    // a low clock enable freezes the sequencer, so a done pulse goes unseen
    @(posedge clk_i) ce <= 1'b0;
    pull_low <= 1'b1;
    repeat (20) @(posedge clk_i);
    pull_low <= 1'b0;
    repeat (5) @(posedge clk_i);
    ce <= 1'b1;
    repeat (10) @(posedge clk_i);
    chk("ce_freeze", 8'h01, cfg);
    $display("test clock_enable done");
    // reset after configuration clears storage only
    @(posedge clk_i) reset_n <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk("user_rst", 8'h03, {cfg, sreset});
    reset_n <= 1'b1;
    repeat (10) @(posedge clk_i);
    dpu_opt <= 1'b0;
    @(negedge clk_i) chk("pullup_opt", 8'h00, dpu);
    $display("test user_reset done");
    stop_test;
  end
endmodule
